// ==== test/hpd_dma_ctrl.sv ====
`timescale 1ns/1ps
module hpd_dma_ctrl
	import hpd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic host_request_n,
	input wire logic [HPD_BYTE_W-1:0] host_data_out,
	output logic dma_acknowledge_n,
	output logic [HPD_BYTE_W-1:0] host_data_in
);
	// Extra cycles the acknowledge stays low
	int hold = 1;
	initial begin
		dma_acknowledge_n = 1'b1;
		host_data_in = 8'h00;
	end
	// bytes go in only when the port asks, so tx bytes are empty
	task automatic xfer(input logic [7:0] wr, output logic [7:0] rd,
		output bit ok);
		int n;
		n = 0;
		rd = 8'h00;
		// Look at the request away from the edge that launches it
		do begin
			@(negedge sys_clk);
			n++;
		end while (host_request_n !== 1'b0 && n < 400);
		ok = (n < 400);
		if (!ok) return;
		dma_acknowledge_n = 1'b0;
		host_data_in = wr;
		repeat (hold + 1) @(posedge sys_clk);
		@(negedge sys_clk);
		rd = host_data_out;
		dma_acknowledge_n = 1'b1;
		// Released bus shows the inverse so a stale latch is caught
		@(negedge sys_clk);
		host_data_in = ~wr;
	endtask
endmodule

// ==== test/hpd_port_assertions.sv ====
`timescale 1ns/1ps
module hpd_port_chk
	import hpd_pkg::*;
(
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic dma_mode_bit0,
	input wire logic dma_mode_bit1,
	input wire logic tx_request_enable,
	input wire logic rx_request_enable,
	input wire logic init_set,
	input wire logic init_busy,
	input wire logic host_request_n,
	input wire logic dma_acknowledge_n,
	input wire logic host_strobe_enable_n,
	input wire logic host_data_oe,
	input wire logic rx_bytes_full,
	input wire logic tx_bytes_empty,
	input wire logic dsp_tx_irq_enable,
	input wire logic dsp_tx_empty,
	input wire logic dsp_tx_exception
);
	default clocking @(posedge sys_clk); endclocking
	default disable iff (srst);
	// Two sync flops plus one blocked update
	sequence strobe_held;
		!host_strobe_enable_n [*3];
	endsequence
	sequence ack_taken;
		!host_request_n && !dma_acknowledge_n;
	endsequence
	req_drop_a: assert property (ack_taken |=> host_request_n)
		else $error("request held under acknowledge");
	tx_exc_a: assert property (
		dsp_tx_exception == (dsp_tx_empty && dsp_tx_irq_enable))
		else $error("transmit exception wrong");
	init_done_a: assert property (init_set |-> ##[1:6] !init_busy)
		else $error("init took too long");
	init_wait_a: assert property (
		$fell(host_request_n) |-> !$past(init_busy))
		else $error("request during init");
	oe_ack_a: assert property (
		host_data_oe |-> !$past(dma_acknowledge_n))
		else $error("bus driven without acknowledge");
	dma_only_a: assert property (
		$fell(host_request_n) |-> $past(dma_mode_bit0 || dma_mode_bit1))
		else $error("request outside dma mode");
	freeze_a: assert property (
		strobe_held ##1 !host_strobe_enable_n |->
		$stable(rx_bytes_full) && $stable(tx_bytes_empty))
		else $error("status moved under strobe");
	rx_req_a: assert property (
		$rose(rx_bytes_full) && rx_request_enable && !tx_request_enable
		&& (dma_mode_bit0 || dma_mode_bit1) |-> ##[0:2] !host_request_n)
		else $error("no request for full rx bytes");
endmodule
bind hpd_port hpd_port_chk u_chk (.*);

// ==== test/hpd_port_tb.sv ====
`timescale 1ns/1ps
module hpd_port_tb;
	import hpd_pkg::*;
	logic sys_clk, srst, dma_mode_bit0, dma_mode_bit1;
	logic tx_request_enable, rx_request_enable, init_set, init_busy;
	logic host_request_n, dma_acknowledge_n, host_strobe_enable_n;
	logic [7:0] host_data_in, host_data_out;
	logic host_data_oe, rx_bytes_full, tx_bytes_empty;
	logic dsp_tx_irq_enable, dsp_rx_irq_enable, dsp_tx_write;
	logic [23:0] dsp_tx_data, dsp_rx_word;
	logic dsp_tx_empty, dsp_tx_exception, dsp_rx_valid, dsp_rx_read;
	logic dsp_rx_exception;
	int n_mismatch = 0;
	int checks_done = 0;
	hpd_port DUT (.*);
	hpd_dma_ctrl dma (.*);
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end
	task automatic check(input logic [23:0] seen, input logic [23:0] exp);
		checks_done++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("wrong value at %0t: %h, expected %h", $time, seen, exp);
		end
	endtask
	task automatic end_of_test();
		$display("mismatches %0d, checks %0d", n_mismatch, checks_done);
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	// host sets size, direction and init
	task automatic set_mode(input logic [1:0] m, input logic h2d);
		int n;
		@(negedge sys_clk);
		{dma_mode_bit1, dma_mode_bit0} = m;
		tx_request_enable = h2d && m != 2'h0;
		rx_request_enable = !h2d && m != 2'h0;
		init_set = 1'b1;
		@(negedge sys_clk);
		init_set = 1'b0;
		n = 1;
		while (init_busy !== 1'b0 && n < 20) begin
			@(negedge sys_clk);
			n++;
		end
		check(24'(n <= 6), 24'h1);
	endtask
	task automatic dsp_write(input logic [23:0] w);
		@(negedge sys_clk);
		dsp_tx_write = 1'b1;
		dsp_tx_data = w;
		@(negedge sys_clk);
		dsp_tx_write = 1'b0;
	endtask
	task automatic pop(output logic [23:0] w);
		int n;
		n = 0;
		@(negedge sys_clk);
		while (dsp_rx_valid !== 1'b1 && n < 50) begin
			@(negedge sys_clk);
			n++;
		end
		check(24'(dsp_rx_exception), 24'h1);
		w = dsp_rx_word;
		dsp_rx_read = 1'b1;
		@(negedge sys_clk);
		dsp_rx_read = 1'b0;
	endtask
	task automatic xfer(input logic [7:0] wr, output logic [7:0] rd);
		bit ok;
		dma.xfer(wr, rd, ok);
		check(24'(ok), 24'h1);
	endtask
	initial begin
		logic [23:0] w, e, mask;
		logic [7:0] r;
		srst = 1'b1;
		{dma_mode_bit1, dma_mode_bit0, init_set} = 3'h0;
		{tx_request_enable, rx_request_enable} = 2'h0;
		{dsp_tx_irq_enable, dsp_tx_write, dsp_rx_read} = 3'h0;
		host_strobe_enable_n = 1'b1;
		dsp_rx_irq_enable = 1'b1;
		dsp_tx_data = 24'h0;
		repeat (12) @(negedge sys_clk);
		srst = 1'b0;
		check({host_request_n, tx_bytes_empty, rx_bytes_full, dsp_tx_empty,
			dsp_rx_valid, init_busy}, 24'h34);
		for (int m = 1; m < 4; m++) begin
			mask = 24'hFF_FFFF >> (8 * (m - 1));
			set_mode(2'(m), 1'b1);
			// tx bytes reached only through the DMA channel
			for (int k = 0; k < 2; k++) begin
				dma.hold = k + 1;
				e = 24'h0;
				for (int i = m - 1; i < 3; i++) begin
					e = {e[15:0], 8'(m * 40 + k * 7 + i)};
					xfer(e[7:0], r);
				end
				pop(w);
				check(w & mask, e & mask);
			end
			set_mode(2'h0, 1'b0);
		end
		// Fill the core FIFO until the port stops requesting
		set_mode(HPD_MODE_8, 1'b1);
		dma.hold = 0;
		for (int i = 0; i < 17; i++) xfer(8'(i), r);
		repeat (8) @(negedge sys_clk);
		check({host_request_n, tx_bytes_empty}, 24'h2);
		for (int i = 0; i < 17; i++) begin
			pop(w);
			check(w[7:0], 8'(i));
		end
		check(24'(dsp_rx_valid), 24'h0);
		check(24'(dsp_rx_exception), 24'h0);
		set_mode(2'h0, 1'b0);
		for (int m = 1; m < 4; m += 2) begin
			mask = 24'hFF_FFFF >> (8 * (m - 1));
			set_mode(2'(m), 1'b0);
			dsp_tx_irq_enable = 1'b1;
			@(negedge sys_clk);
			check(24'(dsp_tx_exception), 24'h1);
			host_strobe_enable_n = 1'b0;
			dsp_write(24'hA1_B2C3);
			repeat (2) @(negedge sys_clk);
			check(24'(rx_bytes_full), 24'h0);
			// strobe stays high long enough to refresh
			host_strobe_enable_n = 1'b1;
			dsp_write(24'h5D_6E7F);
			repeat (2) @(negedge sys_clk);
			// rx bytes are read only once full is seen
			check({dsp_tx_empty, dsp_tx_exception, rx_bytes_full}, 24'h1);
			// rx bytes reached only through the DMA channel
			for (int k = 0; k < 2; k++) begin
				dma.hold = k + 1;
				e = 24'h0;
				for (int i = m - 1; i < 3; i++) begin
					xfer(8'h00, r);
					e = {e[15:0], r};
				end
				w = k ? 24'h5D_6E7F : 24'hA1_B2C3;
				check(e & mask, w & mask);
			end
			dsp_tx_irq_enable = 1'b0;
			set_mode(2'h0, 1'b0);
		end
		end_of_test();
	end
	initial begin
		repeat (20000) @(posedge sys_clk);
		n_mismatch++;
		end_of_test();
	end
endmodule

// ==== verilog/hpd_fifo.sv ====
`timescale 1ns/1ps
module hpd_fifo #(
	parameter int WIDTH = 24,
	parameter int DEPTH = 16
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wr_ptr;
	logic [AW-1:0] rd_ptr;
	logic [AW:0] count;
	logic [AW-1:0] next_wr_ptr;
	logic [AW-1:0] next_rd_ptr;
	logic [AW:0] next_count;
	logic do_wr;
	logic do_rd;

	// Data held in a register so the consumer sees a flop output
	assign in_ready = (count != (AW+1)'(DEPTH));
	assign out_valid = (count != '0);
	assign do_wr = in_valid && in_ready;
	assign do_rd = out_valid && out_ready;

	always_comb begin
		next_wr_ptr = do_wr ? wr_ptr + 1'b1 : wr_ptr;
		next_rd_ptr = do_rd ? rd_ptr + 1'b1 : rd_ptr;
		next_count = count;
		if (do_wr && !do_rd) begin
			next_count = count + 1'b1;
		end else if (do_rd && !do_wr) begin
			next_count = count - 1'b1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			wr_ptr <= '0;
			rd_ptr <= '0;
			count <= '0;
		end else begin
			wr_ptr <= next_wr_ptr;
			rd_ptr <= next_rd_ptr;
			count <= next_count;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (do_wr) begin
			mem[wr_ptr] <= in_data;
		end
	end

	// Show-ahead: head word is a registered copy of the next entry
	always_ff @(posedge sys_clk) begin
		if (srst) begin
			out_data <= '0;
		end else if (do_wr && (count == '0 || (do_rd && count == 1))) begin
			out_data <= in_data;
		end else if (do_rd) begin
			out_data <= mem[next_rd_ptr];
		end else if (count != '0) begin
			out_data <= mem[rd_ptr];
		end
	end
endmodule

// ==== verilog/hpd_pkg.sv ====
package hpd_pkg;
	localparam int HPD_WORD_W = 24;
	localparam int HPD_BYTE_W = 8;
	localparam int HPD_FIFO_DEPTH = 16;
	// Byte register addresses on the host port
	localparam logic [2:0] HPD_ADDR_HIGH = 3'h5;
	localparam logic [2:0] HPD_ADDR_MID = 3'h6;
	localparam logic [2:0] HPD_ADDR_LOW = 3'h7;
	// DMA mode encodings (dma_mode_bit1, dma_mode_bit0)
	localparam logic [1:0] HPD_MODE_OFF = 2'h0;
	localparam logic [1:0] HPD_MODE_24 = 2'h1;
	localparam logic [1:0] HPD_MODE_16 = 2'h2;
	localparam logic [1:0] HPD_MODE_8 = 2'h3;
	// Initialization: 3T sync plus 3T execution, T = one clock here
	localparam int HPD_INIT_SYNC_T = 3;
	localparam int HPD_INIT_EXEC_T = 3;
	localparam logic [2:0] HPD_INIT_CYCLES =
		3'(HPD_INIT_SYNC_T + HPD_INIT_EXEC_T - 1);
	localparam logic [2:0] HPD_INIT_ZERO = 3'h0;
	typedef enum logic [1:0] {
		HPD_IDLE = 2'b00,
		HPD_REQ = 2'b01,
		HPD_ACK = 2'b11
	} hpd_state_e;
endpackage

// ==== verilog/hpd_port.sv ====
`timescale 1ns/1ps
// Notes on behaviour
// - Host-to-DSP DMA: request asserts right after initialization.
// - Three filled transmit bytes move at once to DSP receive word.
// - Transmit exception while tx empty and tx irq enable; write clears.
// - Full clear and empty clear: copy word to rx bytes, set both.
// - On full set in DSP-to-host DMA, load counter, raise request.
// - Acknowledge drives addressed byte; request drops on acknowledge.
// - After acknowledge, non-low byte increments counter, re-requests.
// - Reading low byte clears full; pending word reloads at once.
// - Transmit exception active right after tx irq enable is set.
// - Strobe is synchronized; status updates freeze while it is held.
// - Cancel by clearing pending bit; vector unchanged in that write; this port has no host command, pending bit or vector.
// - Hardware clears init bit when done; host waits for it.
// - Initialization completes within 3T sync plus 3T execution.
// - In DMA mode the request line carries no host interrupt.
// - Low tx byte clears empty, reloads counter; others increment.
module hpd_port
	import hpd_pkg::*;
#(
	parameter int WORD_W = HPD_WORD_W,
	parameter int FIFO_DEPTH = HPD_FIFO_DEPTH
) (
	input wire logic sys_clk,
	input wire logic srst,
	// Host-side control bits
	input wire logic dma_mode_bit0,
	input wire logic dma_mode_bit1,
	input wire logic tx_request_enable,
	input wire logic rx_request_enable,
	input wire logic init_set,
	output logic init_busy,
	// Host DMA pins
	output logic host_request_n,
	input wire logic dma_acknowledge_n,
	input wire logic host_strobe_enable_n,
	input wire logic [HPD_BYTE_W-1:0] host_data_in,
	output logic [HPD_BYTE_W-1:0] host_data_out,
	output logic host_data_oe,
	// Host-visible status, frozen while the strobe is held
	output logic rx_bytes_full,
	output logic tx_bytes_empty,
	// DSP core side
	input wire logic dsp_tx_irq_enable,
	input wire logic dsp_rx_irq_enable,
	input wire logic dsp_tx_write,
	input wire logic [WORD_W-1:0] dsp_tx_data,
	output logic dsp_tx_empty,
	output logic dsp_tx_exception,
	output logic dsp_rx_valid,
	input wire logic dsp_rx_read,
	output logic [WORD_W-1:0] dsp_rx_word,
	output logic dsp_rx_exception
);
	logic [1:0] mode;
	logic h2d;
	logic d2h;
	hpd_state_e state;
	hpd_state_e next_state;
	logic [2:0] baddr;
	logic [2:0] next_baddr;
	logic [WORD_W-1:0] txb;
	logic [WORD_W-1:0] next_txb;
	logic [WORD_W-1:0] rxb;
	logic [WORD_W-1:0] next_rxb;
	logic rx_full_i;
	logic next_rx_full_i;
	logic tx_empty_i;
	logic next_tx_empty_i;
	logic tx_word_empty;
	logic next_tx_word_empty;
	logic [WORD_W-1:0] tx_word;
	logic [WORD_W-1:0] next_tx_word;
	logic [2:0] init_cnt;
	logic [2:0] next_init_cnt;
	logic strb_s1;
	logic strb_s2;
	logic rx_full_hold;
	logic tx_empty_hold;
	logic fifo_in_valid;
	logic fifo_in_ready;
	logic ack_end;
	logic byte_done;

	// Counter start for a new word depends on word size
	function automatic logic [2:0] start_addr(input logic [1:0] m);
		case (m)
			HPD_MODE_24: start_addr = HPD_ADDR_HIGH;
			HPD_MODE_16: start_addr = HPD_ADDR_MID;
			default: start_addr = HPD_ADDR_LOW;
		endcase
	endfunction

	function automatic logic [HPD_BYTE_W-1:0] pick_byte(
		input logic [WORD_W-1:0] w, input logic [2:0] a);
		if (a == HPD_ADDR_HIGH) begin
			pick_byte = w[23:16];
		end else if (a == HPD_ADDR_MID) begin
			pick_byte = w[15:8];
		end else begin
			pick_byte = w[7:0];
		end
	endfunction

	assign mode = {dma_mode_bit1, dma_mode_bit0};
	assign h2d = (mode != HPD_MODE_OFF) && tx_request_enable
		&& !rx_request_enable;
	assign d2h = (mode != HPD_MODE_OFF) && rx_request_enable
		&& !tx_request_enable;
	assign init_busy = (init_cnt != HPD_INIT_ZERO);
	assign ack_end = (state == HPD_ACK) && dma_acknowledge_n;
	assign byte_done = ack_end;

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			strb_s1 <= 1'b0;
			strb_s2 <= 1'b0;
		end else begin
			strb_s1 <= !host_strobe_enable_n;
			strb_s2 <= strb_s1;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			rx_full_hold <= 1'b0;
			tx_empty_hold <= 1'b1;
		end else if (!strb_s2) begin
			rx_full_hold <= rx_full_i;
			tx_empty_hold <= tx_empty_i;
		end
	end
	assign rx_bytes_full = rx_full_hold;
	assign tx_bytes_empty = tx_empty_hold;

	assign dsp_tx_exception = tx_word_empty && dsp_tx_irq_enable;
	assign dsp_tx_empty = tx_word_empty;
	assign dsp_rx_exception = dsp_rx_valid && dsp_rx_irq_enable;

	always_comb begin
		next_state = state;
		next_baddr = baddr;
		next_txb = txb;
		next_rxb = rxb;
		next_rx_full_i = rx_full_i;
		next_tx_empty_i = tx_empty_i;
		next_tx_word_empty = tx_word_empty;
		next_tx_word = tx_word;
		next_init_cnt = init_cnt;
		fifo_in_valid = 1'b0;
		// init counts down, then clears itself
		if (init_set) begin
			next_init_cnt = HPD_INIT_CYCLES;
		end else if (init_busy) begin
			next_init_cnt = init_cnt - 1'b1;
		end
		if (dsp_tx_write) begin
			next_tx_word = dsp_tx_data;
			next_tx_word_empty = 1'b0;
		end
		case (state)
			HPD_IDLE: begin
				if (!init_busy && h2d && tx_empty_i) begin
					next_state = HPD_REQ;
				end else if (!init_busy && d2h && rx_full_i) begin
					next_state = HPD_REQ;
				end
			end
			HPD_REQ: begin
				if (!dma_acknowledge_n) begin
					next_state = HPD_ACK;
				end else if (!(h2d || d2h)) begin
					next_state = HPD_IDLE;
				end
			end
			HPD_ACK: begin
				if (ack_end) begin
					if (h2d) begin
						// Byte latched at the end of acknowledge
						case (baddr)
							HPD_ADDR_HIGH: next_txb[23:16] = host_data_in;
							HPD_ADDR_MID: next_txb[15:8] = host_data_in;
							default: next_txb[7:0] = host_data_in;
						endcase
					end
					if (baddr != HPD_ADDR_LOW) begin
						next_baddr = baddr + 3'h1;
						next_state = HPD_REQ;
					end else begin
						next_baddr = start_addr(mode);
						next_state = HPD_IDLE;
						if (h2d) begin
							next_tx_empty_i = 1'b0;
						end else begin
							next_rx_full_i = 1'b0;
						end
					end
				end
			end
			default: next_state = HPD_IDLE;
		endcase
		// three bytes to core at once, blocked if FIFO full
		if (!next_tx_empty_i && tx_empty_i == 1'b0 && fifo_in_ready) begin
			fifo_in_valid = 1'b1;
			next_tx_empty_i = 1'b1;
			next_baddr = start_addr(mode);
		end
		if (!next_rx_full_i && !tx_word_empty) begin
			next_rxb = tx_word;
			next_rx_full_i = 1'b1;
			next_tx_word_empty = 1'b1;
			if (dsp_tx_write) begin
				next_tx_word_empty = 1'b0;
			end
			next_baddr = start_addr(mode);
		end
		if (init_set || mode == HPD_MODE_OFF) begin
			next_baddr = start_addr(mode);
			next_state = HPD_IDLE;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			state <= HPD_IDLE;
			baddr <= HPD_ADDR_LOW;
			txb <= '0;
			rxb <= '0;
			rx_full_i <= 1'b0;
			tx_empty_i <= 1'b1;
			tx_word_empty <= 1'b1;
			tx_word <= '0;
			init_cnt <= HPD_INIT_ZERO;
		end else begin
			state <= next_state;
			baddr <= next_baddr;
			txb <= next_txb;
			rxb <= next_rxb;
			rx_full_i <= next_rx_full_i;
			tx_empty_i <= next_tx_empty_i;
			tx_word_empty <= next_tx_word_empty;
			tx_word <= next_tx_word;
			init_cnt <= next_init_cnt;
		end
	end

	// request line is DMA-only, no interrupt use
	assign host_request_n = !(state == HPD_REQ);

	always_ff @(posedge sys_clk) begin
		if (srst) begin
			host_data_out <= '0;
			host_data_oe <= 1'b0;
		end else begin
			host_data_out <= pick_byte(rxb, baddr);
			host_data_oe <= d2h && !dma_acknowledge_n
				&& (state != HPD_IDLE) && !byte_done;
		end
	end

	// Words queue toward the core; full FIFO stalls the port
	hpd_fifo #(
		.WIDTH(WORD_W),
		.DEPTH(FIFO_DEPTH)
	) u_rx_fifo (
		.sys_clk(sys_clk),
		.srst(srst),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(txb),
		.out_valid(dsp_rx_valid),
		.out_ready(dsp_rx_read),
		.out_data(dsp_rx_word)
	);
endmodule

// ==== verilog/unused_placeholder_none.sv ====
`timescale 1ns/1ps
